// [rtl/difr_router.sv]
// Drive input function router: synchronises nine input lines and routes
// them to internal control functions under software-set assignments.
// Assumes all lines are asynchronous levels and the register port master
// keeps strobes one cycle long.
//
// Overview of operation
// - Eight selector bits index 256 targets
// - Default: lines 0-3 selectors, line 4 start
// - Lines 4 and 8 are fast inputs; only line 8 samples
// - Sample edge captures actual position
// - Enable, limits hard-wired to lines 5,6,7
// - Assignable functions only on lines 0-4
// - Sample on 8; reference, start on 4/8
// - Each function sourced by one line only
// - One line may drive several functions
// - Limits bound travel, serve as homing reference
// - Enable needs controller enable and torque permit
// - Stop halts positioning and speed control
// - Separate jog inputs per direction
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module difr_router (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Input lines and drive status
    input wire logic [difr_pkg::NUM_LINES-1:0] din,
    input wire logic safe_torque_off_ok,
    input wire logic [difr_pkg::POS_W-1:0] actual_position,
    input wire logic homing_active,
    // Register port
    input wire logic [difr_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Routed functions
    output logic [difr_pkg::SEL_BITS-1:0] target_index,
    output logic positioning_start,
    output logic drive_enable,
    output logic limit_neg,
    output logic limit_pos,
    output logic travel_inhibit_neg,
    output logic travel_inhibit_pos,
    output logic reference_switch,
    output logic homing_start,
    output logic halt_positioning,
    output logic halt_speed,
    output logic jog_neg,
    output logic jog_pos,
    output logic program_home_command,
    output logic program_start_command,
    output logic program_advance_one_command,
    output logic program_advance_two_command,
    output logic program_stop_command,
    output logic program_toggle_command,
    output logic setup_mode,
    output logic [difr_pkg::POS_W-1:0] captured_position,
    output logic capture_strobe
);
    import difr_pkg::*;

    typedef struct packed {
        logic [NUM_FN-1:0][2:0] fn_assign;
        logic [1:0] fast_assign;
        logic [NUM_LINES-1:0] polarity;
        logic [NUM_LINES-1:0] line_prev;
        logic [NUM_FN-1:0] fn_out;
        logic [SEL_BITS-1:0] index;
        logic start_out;
        logic ref_out;
        logic enable_out;
        logic lim_neg_out;
        logic lim_pos_out;
        logic [POS_W-1:0] capture;
        logic cap_pulse;
        logic [31:0] rdata;
    } difr_state_s;

    difr_state_s state_reg;
    difr_state_s state_next;
    logic [NUM_LINES-1:0] line_sync;
    logic [NUM_LINES-1:0] line_act;
    logic [NUM_FN-1:0] fn_level;

    // Every line passes two flops before use
    difr_sync #(.W(NUM_LINES)) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .raw_in(din),
        .sync_out(line_sync)
    );

    assign line_act = line_sync ^ state_reg.polarity;

    // Each function has one source code, so only one line can drive it
    // several functions may name the same line codes above 4 are off
    genvar g;
    generate
        for (g = 0; g < NUM_FN; g++) begin : g_fn
            assign fn_level[g] = (state_reg.fn_assign[g] <= ASSIGN_MAX) ?
                line_act[state_reg.fn_assign[g]] : 1'b0;
        end
    endgenerate

    always_comb begin
        state_next = state_reg;
        state_next.line_prev = line_act;
        state_next.fn_out = fn_level;
        // Selector bits form the target index
        state_next.index = fn_level[FN_SEL0 +: SEL_BITS];
        // Start on line 4 or 8
        state_next.start_out = state_reg.fast_assign[FAST_START_BIT] ?
            line_act[LINE_FAST_B] : line_act[LINE_FAST_A];
        state_next.ref_out = state_reg.fast_assign[FAST_REF_BIT] ?
            line_act[LINE_FAST_B] : line_act[LINE_FAST_A];
        // Fixed lines
        state_next.enable_out = line_act[LINE_ENABLE] & safe_torque_off_ok;
        state_next.lim_neg_out = line_act[LINE_LIMIT_NEG];
        state_next.lim_pos_out = line_act[LINE_LIMIT_POS];
        // Sample input fixed to line 8, rising edge captures
        state_next.cap_pulse = 1'b0;
        if (line_act[LINE_FAST_B] && !state_reg.line_prev[LINE_FAST_B]) begin
            state_next.capture = actual_position;
            state_next.cap_pulse = 1'b1;
        end
        // Register writes
        if (reg_wr) begin
            if (reg_addr < OFS_FN_ASSIGN_BASE + 8'(4 * NUM_FN) && reg_addr[1:0] == 2'h0) begin
                state_next.fn_assign[reg_addr[6:2]] = reg_wdata[2:0];
            end else if (reg_addr == OFS_FAST_ASSIGN) begin
                state_next.fast_assign = reg_wdata[1:0];
            end else if (reg_addr == OFS_POLARITY) begin
                state_next.polarity = reg_wdata[NUM_LINES-1:0];
            end
        end
        // Reads answer next cycle; unmapped reads zero
        state_next.rdata = 32'h0;
        if (reg_rd) begin
            if (reg_addr < OFS_FN_ASSIGN_BASE + 8'(4 * NUM_FN) && reg_addr[1:0] == 2'h0) begin
                state_next.rdata = {29'h0, state_reg.fn_assign[reg_addr[6:2]]};
            end else if (reg_addr == OFS_FAST_ASSIGN) begin
                state_next.rdata = {30'h0, state_reg.fast_assign};
            end else if (reg_addr == OFS_POLARITY) begin
                state_next.rdata = {23'h0, state_reg.polarity};
            end else if (reg_addr == OFS_LINE_STATE) begin
                state_next.rdata = {23'h0, line_act};
            end else if (reg_addr == OFS_FN_STATE) begin
                state_next.rdata = {13'h0, state_reg.fn_out};
            end else if (reg_addr == OFS_CAPTURE) begin
                state_next.rdata = state_reg.capture;
            end else if (reg_addr == OFS_TARGET_IDX) begin
                state_next.rdata = {24'h0, state_reg.index};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_FN; i++) begin
                state_reg.fn_assign[i] <= fn_assign_rst(i);
            end
            state_reg.fast_assign <= FAST_ASSIGN_RST;
            state_reg.polarity <= '0;
            state_reg.line_prev <= '0;
            state_reg.fn_out <= '0;
            state_reg.index <= '0;
            state_reg.start_out <= 1'b0;
            state_reg.ref_out <= 1'b0;
            state_reg.enable_out <= 1'b0;
            state_reg.lim_neg_out <= 1'b0;
            state_reg.lim_pos_out <= 1'b0;
            state_reg.capture <= '0;
            state_reg.cap_pulse <= 1'b0;
            state_reg.rdata <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign target_index = state_reg.index;
    assign positioning_start = state_reg.start_out;
    assign reference_switch = state_reg.ref_out;
    assign drive_enable = state_reg.enable_out;
    assign limit_neg = state_reg.lim_neg_out;
    assign limit_pos = state_reg.lim_pos_out;
    // Limits block travel toward them except while homing uses them as reference
    assign travel_inhibit_neg = state_reg.lim_neg_out & ~homing_active;
    assign travel_inhibit_pos = state_reg.lim_pos_out & ~homing_active;
    assign homing_start = state_reg.fn_out[FN_HOME_START];
    assign halt_positioning = state_reg.fn_out[FN_STOP];
    assign halt_speed = state_reg.fn_out[FN_STOP];
    assign jog_neg = state_reg.fn_out[FN_JOG_NEG];
    assign jog_pos = state_reg.fn_out[FN_JOG_POS];
    assign program_home_command = state_reg.fn_out[FN_PROG_HOME];
    assign program_start_command = state_reg.fn_out[FN_PROG_START];
    assign program_advance_one_command = state_reg.fn_out[FN_PROG_ADV1];
    assign program_advance_two_command = state_reg.fn_out[FN_PROG_ADV2];
    assign program_stop_command = state_reg.fn_out[FN_PROG_STOP];
    assign program_toggle_command = state_reg.fn_out[FN_PROG_TOGGLE];
    assign setup_mode = state_reg.fn_out[FN_SETUP];
    assign captured_position = state_reg.capture;
    assign capture_strobe = state_reg.cap_pulse;
    assign reg_rdata = state_reg.rdata;

    AST_ENABLE_GATED: assert property (@(posedge clk_sys) disable iff (!resetn)
        drive_enable |-> $past(safe_torque_off_ok))
        else $error("enable without torque permit");
    AST_CAPTURE_VALUE: assert property (@(posedge clk_sys) disable iff (!resetn)
        capture_strobe |-> captured_position == $past(actual_position))
        else $error("capture value wrong");
    AST_CAPTURE_EDGE: assert property (@(posedge clk_sys) disable iff (!resetn)
        capture_strobe |-> $past(line_act[LINE_FAST_B]) && !$past(line_act[LINE_FAST_B], 2))
        else $error("capture not on line 8 edge");
    AST_STOP_BOTH: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_reg.fn_assign[FN_STOP] == 3'h2 |=>
        halt_positioning == $past(line_act[2]) && halt_speed == halt_positioning)
        else $error("stop halts differ");
    AST_LIMIT_NEG: assert property (@(posedge clk_sys) disable iff (!resetn)
        limit_neg == $past(line_act[LINE_LIMIT_NEG]))
        else $error("limit 0 not from line 6");
    AST_LIMIT_POS: assert property (@(posedge clk_sys) disable iff (!resetn)
        limit_pos == $past(line_act[LINE_LIMIT_POS]))
        else $error("limit 1 not from line 7");
    AST_JOG_NEG: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_reg.fn_assign[FN_JOG_NEG] > ASSIGN_MAX |=> !jog_neg)
        else $error("unassigned jog active");
    AST_START_SRC: assert property (@(posedge clk_sys) disable iff (!resetn)
        !state_reg.fast_assign[FAST_START_BIT] |=> positioning_start == $past(line_act[LINE_FAST_A]))
        else $error("start not from line 4");
    AST_SEL_INDEX: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_reg.fn_assign[FN_SEL0] == 3'h0 |=> target_index[0] == $past(line_act[0]))
        else $error("index bit 0 not from line 0");
    AST_READ_LATENCY: assert property (@(posedge clk_sys) disable iff (!resetn)
        !reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside answer cycle");
endmodule : difr_router
`default_nettype wire

// [rtl/difr_pkg.sv]
// Package for the drive input function router: line numbers, function
// selectors, register map and reset values.
// Assumes a 50 MHz system clock and a plain address/strobe register port.
package difr_pkg;

    localparam int NUM_LINES = 9;
    localparam int SEL_BITS = 8;
    localparam int POS_W = 32;
    localparam int ADDR_W = 8;

    // Hard-wired lines
    localparam int LINE_ENABLE = 5;
    localparam int LINE_LIMIT_NEG = 6;
    localparam int LINE_LIMIT_POS = 7;
    localparam int LINE_FAST_A = 4;
    localparam int LINE_FAST_B = 8;

    // Assignment code: 0..4 selects a line, 7 means unassigned
    localparam logic [2:0] ASSIGN_NONE = 3'h7;
    localparam logic [2:0] ASSIGN_MAX = 3'h4;

    // Function indices for the assignable group (lines 0..4 only)
    localparam int FN_SEL0 = 0;
    localparam int FN_STOP = 8;
    localparam int FN_JOG_NEG = 9;
    localparam int FN_JOG_POS = 10;
    localparam int FN_HOME_START = 11;
    localparam int FN_PROG_HOME = 12;
    localparam int FN_PROG_START = 13;
    localparam int FN_PROG_ADV1 = 14;
    localparam int FN_PROG_ADV2 = 15;
    localparam int FN_PROG_STOP = 16;
    localparam int FN_PROG_TOGGLE = 17;
    localparam int FN_SETUP = 18;
    localparam int NUM_FN = 19;

    // Register offsets; the assignment words fill 0x00..0x48, the rest sit above them
    localparam logic [ADDR_W-1:0] OFS_FN_ASSIGN_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FAST_ASSIGN = 8'h50;
    localparam logic [ADDR_W-1:0] OFS_POLARITY = 8'h54;
    localparam logic [ADDR_W-1:0] OFS_LINE_STATE = 8'h58;
    localparam logic [ADDR_W-1:0] OFS_FN_STATE = 8'h5C;
    localparam logic [ADDR_W-1:0] OFS_CAPTURE = 8'h60;
    localparam logic [ADDR_W-1:0] OFS_TARGET_IDX = 8'h64;

    // Fast-line assignment field bits (0 = line 4, 1 = line 8)
    localparam int FAST_START_BIT = 0;
    localparam int FAST_REF_BIT = 1;
    localparam logic [1:0] FAST_ASSIGN_RST = 2'h2;

    // Reset assignments: selector bits 0..3 on lines 0..3, rest unassigned
    function automatic logic [2:0] fn_assign_rst(input int fn);
        if (fn < 4) begin
            return 3'(fn);
        end
        return ASSIGN_NONE;
    endfunction : fn_assign_rst

    typedef enum logic [1:0] {
        DIFR_CAP_IDLE,
        DIFR_CAP_ARMED
    } difr_cap_e;

endpackage : difr_pkg

// [rtl/difr_sync.sv]
// Two-stage synchroniser bank for the input lines.
// Assumes inputs may change at any time relative to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module difr_sync #(
    parameter int W = 9
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Lines
    input wire logic [W-1:0] raw_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } difr_sync_s;

    difr_sync_s state_reg;
    difr_sync_s state_next;

    always_comb begin
        state_next = state_reg;
        state_next.stage1 = raw_in;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stage2;
endmodule : difr_sync
`default_nettype wire

// [test/difr_switch_model.sv]
// Model of the external switches or supervising controller on the lines.
// Assumes the bench states the wanted line levels once per clock.
`timescale 1ns/1ps
`default_nettype none
module difr_switch_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Wanted switch levels
    input wire logic [8:0] want,
    // Lines to the drive
    output logic [8:0] din
);
    // Contacts move one clock after the request, on the rising clk_sys edge that the synchroniser also samples on
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            din <= 9'h000;
        end else begin
            din <= want;
        end
    end
endmodule : difr_switch_model
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the input function router.
// Assumes the switch model in front of the lines and a 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import difr_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [8:0] lines = 9'h000;
    logic sto_ok = 1'b1;
    logic [31:0] apos = 32'h0;
    logic homing = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    wire logic [8:0] din;
    logic [31:0] rdata, cpos, r;
    logic [7:0] tidx;
    logic st, en, ln, lp, tn, tp, rs, hs, hp, hsp, jn, jp, ph, ps, pa1, pa2, pst, ptg, sm, cs;
    int mismatches = 0;
    int checked = 0;
    logic [31:0] seed = 32'd70;

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    difr_switch_model sw (.clk_sys(clk_sys), .resetn(resetn), .want(lines), .din(din));

    difr_router uut (.clk_sys(clk_sys), .resetn(resetn), .din(din), .safe_torque_off_ok(sto_ok),
        .actual_position(apos), .homing_active(homing), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .target_index(tidx), .positioning_start(st),
        .drive_enable(en), .limit_neg(ln), .limit_pos(lp), .travel_inhibit_neg(tn),
        .travel_inhibit_pos(tp), .reference_switch(rs), .homing_start(hs), .halt_positioning(hp),
        .halt_speed(hsp), .jog_neg(jn), .jog_pos(jp), .program_home_command(ph),
        .program_start_command(ps), .program_advance_one_command(pa1),
        .program_advance_two_command(pa2), .program_stop_command(pst),
        .program_toggle_command(ptg), .setup_mode(sm), .captured_position(cpos), .capture_strobe(cs));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // Default routing: selectors on 0..3, start on 4, enable gated by torque permit
    function automatic logic [12:0] dexp(input logic [8:0] l, input logic ok);
        return {4'h0, l[3:0], l[4], l[5] & ok, l[6], l[7], l[8]};
    endfunction : dexp

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up;
        if (mismatches == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rreg

    // Model stage, two synchroniser stages and the output register
    task automatic drive(input logic [8:0] l);
        @(posedge clk_sys);
        lines <= l;
        repeat (5) @(posedge clk_sys);
        #1;
    endtask : drive

    initial begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int f = 0; f < 6; f++) begin
            rreg(8'(4 * f), r);
            chk(r, f < 4 ? 32'(f) : 32'h7);
        end
        rreg(OFS_FAST_ASSIGN, r);
        chk(r, 32'h2);
        rreg(8'h80, r);
        chk(r, 32'h0);
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            @(posedge clk_sys);
            sto_ok <= seed[9];
            drive(seed[8:0]);
            chk({tidx, st, en, ln, lp, rs}, dexp(lines, sto_ok));
        end
        @(posedge clk_sys);
        sto_ok <= 1'b1;
        homing <= 1'b1;
        drive(9'h0C0);
        chk({tn, tp}, 2'b00);
        @(posedge clk_sys);
        homing <= 1'b0;
        drive(9'h0C0);
        chk({tn, tp}, 2'b11);
        for (int f = 4; f < NUM_FN; f++) begin
            wreg(8'(4 * f), 32'h0);
        end
        drive(9'h001);
        chk({tidx[7:4], tidx[0], hp, hsp, jn, jp, hs, ph, ps, pa1, pa2, pst, ptg, sm}, 17'h1FFFF);
        drive(9'h1FE);
        chk({tidx[7:4], tidx[0], hp, hsp, jn, jp, hs, ph, ps, pa1, pa2, pst, ptg, sm}, 17'h0);
        wreg(8'(4 * FN_JOG_NEG), 32'h5);
        wreg(8'(4 * FN_JOG_POS), 32'h4);
        wreg(8'(4 * FN_STOP), 32'h2);
        drive(9'h1F1);
        chk({jn, jp, hp}, 3'b010);
        drive(9'h004);
        chk({jn, jp, hp, hsp}, 4'b0011);
        wreg(OFS_FAST_ASSIGN, 32'h1);
        drive(9'h100);
        chk({st, rs}, 2'b10);
        drive(9'h010);
        chk({st, rs}, 2'b01);
        // Invert line 0: selectors 0,4..7 and functions 11..18 sit on it
        wreg(OFS_POLARITY, 32'h1);
        drive(9'h000);
        rreg(OFS_POLARITY, r);
        chk(r, 32'h1);
        rreg(OFS_LINE_STATE, r);
        chk(r, 32'h1);
        rreg(OFS_TARGET_IDX, r);
        chk(r, 32'hF1);
        rreg(OFS_FN_STATE, r);
        chk(r, 32'h7F8F1);
        chk({tidx, hs}, 9'h1E3);
        seed = xs(seed);
        @(posedge clk_sys);
        apos <= seed;
        drive(9'h000);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            lines <= 9'h010;
            #1;
            chk(cs, 1'b0);
        end
        @(posedge clk_sys);
        lines <= 9'h100;
        for (int i = 0; i < 8 && cs !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (cs !== 1'b1) begin
            mismatches++;
        end else begin
            chk(cpos, apos);
            rreg(OFS_CAPTURE, r);
            chk(r, apos);
        end
        wrap_up();
    end
endmodule : tb
`default_nettype wire
